// >>> src/rldcc_pkg.sv
// rldcc_pkg: register map, field layout, reset values, timing and codes
// for the radio link duty-cycle and configuration block.
// assumes a 100 MHz system clock and the plain register port.
package rldcc_pkg;
   // clock and millisecond tick
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_NET = 8'h04;
   localparam logic [7:0] ADR_RADDR = 8'h08;
   localparam logic [7:0] ADR_BAUD = 8'h0c;
   localparam logic [7:0] ADR_IDLE = 8'h10;
   localparam logic [7:0] ADR_NODE = 8'h14;
   localparam logic [7:0] ADR_STAT = 8'h18;
   // control register fields, and the hop field of the network register
   localparam int IFC_LSB = 0;
   localparam int PROTO_LSB = 4;
   localparam int PWR_LSB = 8;
   localparam int RETRY_LSB = 12;
   localparam int HOP_LSB = 8;
   // interface codes
   localparam logic [2:0] IFC_SYNC = 3'h0;
   localparam logic [2:0] IFC_RS232 = 3'h1;
   localparam logic [2:0] IFC_USB = 3'h2;
   localparam logic [2:0] IFC_REPEATER = 3'h3;
   localparam logic [2:0] IFC_MODEM = 3'h4;
   // protocol codes
   localparam logic [1:0] PROTO_TRANSP = 2'h0;
   localparam logic [1:0] PROTO_AWARE = 2'h1;
   localparam logic [1:0] PROTO_NODE = 2'h2;
   // power mode codes and the no-retry code
   localparam logic [2:0] PWR_ON_NOHDR = 3'h0;
   localparam logic [2:0] PWR_ON_HDR1 = 3'h1;
   localparam logic [2:0] PWR_ON_HDR8 = 3'h2;
   localparam logic [2:0] PWR_HALF = 3'h3;
   localparam logic [2:0] PWR_ONE = 3'h4;
   localparam logic [2:0] PWR_EIGHT = 3'h5;
   localparam logic [1:0] RETRY_NONE = 2'h0;
   // value limits
   localparam logic [5:0] NET_MAX_ROUTED = 6'h03;
   // times in milliseconds
   localparam logic [13:0] HDR_HALF_MS = 14'd700;
   localparam logic [13:0] HDR_ONE_MS = 14'd1200;
   localparam logic [13:0] HDR_EIGHT_MS = 14'd8200;
   localparam logic [13:0] PER_HALF_MS = 14'd500;
   localparam logic [13:0] PER_ONE_MS = 14'd1000;
   localparam logic [13:0] PER_EIGHT_MS = 14'd8000;
   localparam logic [13:0] RX_ON_MS = 14'd100;
   // reset values
   localparam logic [15:0] CTRL_RST = 16'h0012;
   localparam logic [15:0] IDLE_RST = 16'd1000;
   localparam logic [15:0] IDLE_CNT_RST = 16'hffff;
   localparam logic [3:0] BAUD_RST = 4'h0;
   typedef enum logic [0:0] {ST_IDLE, ST_HEADER} rldcc_state_t;
endpackage : rldcc_pkg

// >>> src/rldcc_top.sv
// rldcc_top: register file, protocol selection, link matching and the
// receiver duty cycle / wakeup header scheduler of one data radio.
// assumes synchronous inputs, one-cycle TX_REQ and RX_VALID pulses.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rldcc_top #(
   parameter int unsigned MS_CYCLES = rldcc_pkg::MS_CYCLES
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic TX_REQ,
   output logic TX_READY,
   output logic TX_GO,
   output logic HDR_ON,
   output logic RX_PWR,
   input wire logic RX_VALID,
   input wire logic [3:0] RX_HOP,
   input wire logic [5:0] RX_NET,
   input wire logic [9:0] RX_ADDR,
   output logic RX_ACCEPT,
   input wire logic [11:0] SER_ROUTE_ADDR,
   output logic [11:0] RF_ID,
   output logic RAW_FWD,
   output logic ACK_EN,
   output logic RETRY_EN,
   output logic BAUD_EN,
   output logic [3:0] BAUD_SEL
);
   typedef struct packed {
      logic [2:0] ifc;
      logic [1:0] proto;
      logic [2:0] pwr;
      logic [1:0] retry;
      logic [5:0] net;
      logic [3:0] hop;
      logic [9:0] raddr;
      logic [3:0] baud;
      logic [15:0] idle_ms;
      logic [11:0] node;
      logic reject;
      logic [15:0] rdata;
      logic [31:0] div;
      logic [13:0] phase;
      logic [15:0] idle_cnt;
      logic [13:0] hdr_cnt;
      rldcc_pkg::rldcc_state_t state;
      logic tx_go;
      logic rx_acc;
      logic [11:0] rf_id;
   } rldcc_st_t;

   rldcc_st_t s_r;
   rldcc_st_t s_nxt;
   logic tick;
   logic inactive;
   logic always_on;
   logic [13:0] hdr_len;
   logic [13:0] period;
   logic bad_ctrl;
   logic bad_net;
   logic bad_raddr;
   logic [1:0] w_proto;
   logic [1:0] w_retry;
   logic [2:0] w_ifc;
   logic [2:0] w_pwr;
   logic pkt_match;

   // mode dependent header length and sensing period
   always_comb begin
      hdr_len = 14'd0;
      period = rldcc_pkg::PER_ONE_MS;
      always_on = 1'b1;
      case (s_r.pwr)
         rldcc_pkg::PWR_ON_NOHDR: hdr_len = 14'd0;
         rldcc_pkg::PWR_ON_HDR1: hdr_len = rldcc_pkg::HDR_ONE_MS;
         rldcc_pkg::PWR_ON_HDR8: hdr_len = rldcc_pkg::HDR_EIGHT_MS;
         rldcc_pkg::PWR_HALF: begin
            hdr_len = rldcc_pkg::HDR_HALF_MS;
            period = rldcc_pkg::PER_HALF_MS;
            always_on = 1'b0;
         end
         rldcc_pkg::PWR_ONE: begin
            hdr_len = rldcc_pkg::HDR_ONE_MS;
            period = rldcc_pkg::PER_ONE_MS;
            always_on = 1'b0;
         end
         rldcc_pkg::PWR_EIGHT: begin
            hdr_len = rldcc_pkg::HDR_EIGHT_MS;
            period = rldcc_pkg::PER_EIGHT_MS;
            always_on = 1'b0;
         end
         default: hdr_len = 14'd0;
      endcase
   end

   // write validation against the protocol that will be in force
   assign w_ifc = WDATA[rldcc_pkg::IFC_LSB +: 3];
   assign w_proto = WDATA[rldcc_pkg::PROTO_LSB +: 2];
   assign w_pwr = WDATA[rldcc_pkg::PWR_LSB +: 3];
   assign w_retry = WDATA[rldcc_pkg::RETRY_LSB +: 2];
   assign bad_ctrl = (w_proto == rldcc_pkg::PROTO_TRANSP && w_retry != rldcc_pkg::RETRY_NONE)
      || (w_proto != rldcc_pkg::PROTO_TRANSP && s_r.net > rldcc_pkg::NET_MAX_ROUTED)
      || (w_ifc == rldcc_pkg::IFC_REPEATER && w_proto != rldcc_pkg::PROTO_NODE)
      || w_proto > rldcc_pkg::PROTO_NODE || w_pwr > rldcc_pkg::PWR_EIGHT || w_ifc > rldcc_pkg::IFC_MODEM;
   assign bad_net = (WDATA[7:6] != 2'h0)
      || (s_r.proto != rldcc_pkg::PROTO_TRANSP && WDATA[5:0] > rldcc_pkg::NET_MAX_ROUTED);
   assign bad_raddr = WDATA[15:10] != 6'h00;

   assign tick = s_r.div == 32'(MS_CYCLES - 1);
   assign inactive = s_r.idle_cnt >= s_r.idle_ms;
   // hop, network and, in transparent mode only, radio address must agree
   assign pkt_match = RX_VALID && RX_HOP == s_r.hop && RX_NET == s_r.net
      && (s_r.proto != rldcc_pkg::PROTO_TRANSP || RX_ADDR == s_r.raddr);

   // next-state logic for registers, counters and the header sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.tx_go = 1'b0;
      s_nxt.rx_acc = pkt_match;
      s_nxt.div = tick ? 32'h0 : s_r.div + 32'h1;
      if (tick) begin
         s_nxt.phase = (s_r.phase >= period - 14'd1) ? 14'd0 : s_r.phase + 14'd1;
      end
      if (tick && s_r.idle_cnt != 16'hffff) begin
         s_nxt.idle_cnt = s_r.idle_cnt + 16'h1;
      end
      // register writes; rejected values leave the old setting in place
      if (WR) begin
         case (ADDR)
            rldcc_pkg::ADR_CTRL: begin
               if (bad_ctrl) begin
                  s_nxt.reject = 1'b1;
               end else begin
                  s_nxt.ifc = w_ifc;
                  s_nxt.proto = w_proto;
                  s_nxt.pwr = w_pwr;
                  s_nxt.retry = w_retry;
               end
            end
            rldcc_pkg::ADR_NET: begin
               if (bad_net) begin
                  s_nxt.reject = 1'b1;
               end else begin
                  s_nxt.net = WDATA[5:0];
                  s_nxt.hop = WDATA[rldcc_pkg::HOP_LSB +: 4];
               end
            end
            rldcc_pkg::ADR_RADDR: begin
               if (bad_raddr) begin
                  s_nxt.reject = 1'b1;
               end else begin
                  s_nxt.raddr = WDATA[9:0];
               end
            end
            rldcc_pkg::ADR_BAUD: s_nxt.baud = WDATA[3:0];
            rldcc_pkg::ADR_IDLE: s_nxt.idle_ms = WDATA;
            rldcc_pkg::ADR_NODE: s_nxt.node = WDATA[11:0];
            // clear is one-to-clear; a reject in the same write cannot occur here
            rldcc_pkg::ADR_STAT: if (WDATA[0]) s_nxt.reject = 1'b0;
            default: s_nxt.reject = s_r.reject;
         endcase
      end
      // read data stands only in the cycle after the strobe
      s_nxt.rdata = 16'h0000;
      if (RD) begin
         case (ADDR)
            rldcc_pkg::ADR_CTRL: s_nxt.rdata = {2'h0, s_r.retry, 1'b0, s_r.pwr, 2'h0, s_r.proto, 1'b0, s_r.ifc};
            rldcc_pkg::ADR_NET: s_nxt.rdata = {4'h0, s_r.hop, 2'h0, s_r.net};
            rldcc_pkg::ADR_RADDR: s_nxt.rdata = {6'h00, s_r.raddr};
            rldcc_pkg::ADR_BAUD: s_nxt.rdata = {12'h000, s_r.baud};
            rldcc_pkg::ADR_IDLE: s_nxt.rdata = s_r.idle_ms;
            rldcc_pkg::ADR_NODE: s_nxt.rdata = {4'h0, s_r.node};
            rldcc_pkg::ADR_STAT: s_nxt.rdata = {12'h000, RX_PWR, HDR_ON, inactive, s_r.reject};
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
      // header sequencer: an idle link gets the mode's wakeup header first
      case (s_r.state)
         rldcc_pkg::ST_IDLE: begin
            if (TX_REQ) begin
               if (inactive && hdr_len != 14'd0) begin
                  s_nxt.state = rldcc_pkg::ST_HEADER;
                  s_nxt.hdr_cnt = 14'd0;
               end else begin
                  s_nxt.tx_go = 1'b1;
               end
            end
         end
         rldcc_pkg::ST_HEADER: begin
            if (tick) begin
               s_nxt.hdr_cnt = s_r.hdr_cnt + 14'd1;
               if (s_r.hdr_cnt == hdr_len - 14'd1) begin
                  s_nxt.state = rldcc_pkg::ST_IDLE;
                  s_nxt.tx_go = 1'b1;
               end
            end
         end
         default: s_nxt.state = rldcc_pkg::ST_IDLE;
      endcase
      // each send (tx_go) and each matching received packet restarts the idle timer
      if (s_nxt.tx_go || pkt_match) begin
         s_nxt.idle_cnt = 16'h0;
      end
      // RF identity depends on protocol
      case (s_r.proto)
         rldcc_pkg::PROTO_AWARE: s_nxt.rf_id = SER_ROUTE_ADDR;
         rldcc_pkg::PROTO_NODE: s_nxt.rf_id = s_r.node;
         default: s_nxt.rf_id = {2'h0, s_r.raddr};
      endcase
   end

   // one register for all state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s_r <= '0;
         s_r.ifc <= rldcc_pkg::CTRL_RST[rldcc_pkg::IFC_LSB +: 3];
         s_r.proto <= rldcc_pkg::CTRL_RST[rldcc_pkg::PROTO_LSB +: 2];
         s_r.idle_ms <= rldcc_pkg::IDLE_RST;
         s_r.idle_cnt <= rldcc_pkg::IDLE_CNT_RST;
         s_r.baud <= rldcc_pkg::BAUD_RST;
         s_r.state <= rldcc_pkg::ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs; receiver power follows mode flops and the phase counter
   assign RDATA = s_r.rdata;
   assign TX_GO = s_r.tx_go;
   assign TX_READY = s_r.state == rldcc_pkg::ST_IDLE;
   assign HDR_ON = s_r.state == rldcc_pkg::ST_HEADER;
   assign RX_PWR = always_on || s_r.phase < rldcc_pkg::RX_ON_MS;
   assign RX_ACCEPT = s_r.rx_acc;
   assign RF_ID = s_r.rf_id;
   assign RAW_FWD = s_r.proto == rldcc_pkg::PROTO_TRANSP;
   assign ACK_EN = s_r.proto != rldcc_pkg::PROTO_TRANSP;
   assign RETRY_EN = ACK_EN && s_r.retry != rldcc_pkg::RETRY_NONE;
   assign BAUD_EN = s_r.ifc == rldcc_pkg::IFC_RS232;
   assign BAUD_SEL = BAUD_EN ? s_r.baud : rldcc_pkg::BAUD_RST;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   baud_gate_a: assert property (!BAUD_EN |-> BAUD_SEL == rldcc_pkg::BAUD_RST)
      else $error("baud applied off the serial port");
   transp_retry_a: assert property (RAW_FWD |-> !RETRY_EN && !ACK_EN)
      else $error("retries active in transparent mode");
   aware_id_a: assert property (ACK_EN && s_r.proto == rldcc_pkg::PROTO_AWARE && $stable(SER_ROUTE_ADDR)
      |=> s_r.proto != rldcc_pkg::PROTO_AWARE || RF_ID == $past(SER_ROUTE_ADDR))
      else $error("rf id not inherited");
   routed_net_a: assert property (ACK_EN |-> s_r.net <= rldcc_pkg::NET_MAX_ROUTED)
      else $error("routed network out of range");
   hop_net_a: assert property (RX_VALID && (RX_HOP != s_r.hop || RX_NET != s_r.net) |=> !RX_ACCEPT)
      else $error("foreign packet accepted");
   addr_match_a: assert property (RX_VALID && RAW_FWD && RX_ADDR != s_r.raddr |=> !RX_ACCEPT)
      else $error("address mismatch accepted");
   reject_net_a: assert property (WR && ADDR == rldcc_pkg::ADR_NET && bad_net
      |=> s_r.reject && $stable(s_r.net))
      else $error("bad network number applied");
   no_hdr_a: assert property (s_r.pwr == rldcc_pkg::PWR_ON_NOHDR && TX_READY && TX_REQ |=> TX_GO && !HDR_ON)
      else $error("header in no-header mode");
   hdr_start_a: assert property (TX_READY && TX_REQ && inactive && hdr_len != 14'd0 |=> HDR_ON && !TX_GO)
      else $error("idle link sent without header");
   hdr_end_a: assert property ($fell(HDR_ON) |-> TX_GO && $past(s_r.hdr_cnt) == hdr_len - 14'd1)
      else $error("header length wrong");
   // window edges must sit on the phase wrap and on the 100 ms mark; mode switches are skipped
   duty_a: assert property (!always_on && $stable(s_r.pwr) && $changed(RX_PWR)
      |-> s_r.phase == (RX_PWR ? 14'd0 : rldcc_pkg::RX_ON_MS))
      else $error("receiver duty wrong");
   on_a: assert property (always_on |-> RX_PWR)
      else $error("receiver off in always-on mode");

   hdr_c: cover property (HDR_ON ##1 !HDR_ON);
   acc_c: cover property (RX_ACCEPT);
   rej_c: cover property (s_r.reject);
   duty_c: cover property (!always_on && $fell(RX_PWR));
endmodule : rldcc_top

// >>> verif/rldcc_peer_model.sv
// rldcc_peer_model: a peer radio that hands one received packet to the block.
// assumes the bench raises send for one cycle, just after a rising edge.
`timescale 1ns/1ps
module rldcc_peer_model (
   input wire logic clk,
   input wire logic send,
   input wire logic [3:0] hop,
   input wire logic [5:0] net,
   input wire logic [9:0] addr,
   output logic valid,
   output logic [3:0] hop_o,
   output logic [5:0] net_o,
   output logic [9:0] addr_o
);
   // fields toggle outside a packet so a stale value never looks like a match
   always_ff @(posedge clk) begin
      valid <= send;
      if (send) begin
         hop_o <= hop;
         net_o <= net;
         addr_o <= addr;
      end else begin
         hop_o <= ~hop_o;
         net_o <= ~net_o;
         addr_o <= ~addr_o;
      end
   end
endmodule : rldcc_peer_model

// >>> verif/rldcc_top_tb_top.sv
// rldcc_top_tb_top: self-checking bench for the duty-cycle and config block.
// assumes MS_CYCLES shortened to 10, so one millisecond is ten clocks.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module rldcc_top_tb_top;
   localparam int MSC = 10;
   typedef struct packed {
      logic [15:0] ctrl;
      logic raw;
      logic ack;
      logic retry;
      logic baud_en;
      logic [3:0] baud_sel;
   } rldcc_row_t;
   // control word beside the mode outputs it should give, baud code 5 stored
   rldcc_row_t rows [6] = '{'{16'h0001, 1'b1, 1'b0, 1'b0, 1'b1, 4'h5}, '{16'h1011, 1'b0, 1'b1, 1'b1, 1'b1, 4'h5},
      '{16'h0022, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0}, '{16'h0023, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0},
      '{16'h0004, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0}, '{16'h2010, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0}};
   int errors = 0;
   int compares = 0;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [15:0] WDATA = 16'h0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic TX_REQ = 1'b0;
   logic send = 1'b0;
   logic [3:0] p_hop = 4'h0;
   logic [5:0] p_net = 6'h00;
   logic [9:0] p_addr = 10'h000;
   logic [11:0] SER_ROUTE_ADDR = 12'h5a5;
   logic [15:0] RDATA;
   logic TX_READY, TX_GO, HDR_ON, RX_PWR, RX_VALID, RX_ACCEPT, RAW_FWD, ACK_EN, RETRY_EN, BAUD_EN;
   logic [3:0] RX_HOP, BAUD_SEL;
   logic [5:0] RX_NET;
   logic [9:0] RX_ADDR;
   logic [11:0] RF_ID;
   always #5 MCLK = ~MCLK;
   rldcc_top #(.MS_CYCLES(MSC)) rldcc_top_inst (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .TX_REQ(TX_REQ), .TX_READY(TX_READY), .TX_GO(TX_GO), .HDR_ON(HDR_ON),
      .RX_PWR(RX_PWR), .RX_VALID(RX_VALID), .RX_HOP(RX_HOP), .RX_NET(RX_NET), .RX_ADDR(RX_ADDR),
      .RX_ACCEPT(RX_ACCEPT), .SER_ROUTE_ADDR(SER_ROUTE_ADDR), .RF_ID(RF_ID), .RAW_FWD(RAW_FWD),
      .ACK_EN(ACK_EN), .RETRY_EN(RETRY_EN), .BAUD_EN(BAUD_EN), .BAUD_SEL(BAUD_SEL));
   rldcc_peer_model rldcc_peer_model_inst (.clk(MCLK), .send(send), .hop(p_hop), .net(p_net), .addr(p_addr),
      .valid(RX_VALID), .hop_o(RX_HOP), .net_o(RX_NET), .addr_o(RX_ADDR));
   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   // one-cycle strobes; each task starts on a fresh edge so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 `CHK(RDATA, exp)
   endtask : rdc
   task automatic rx(input logic [3:0] h, input logic [5:0] n, input logic [9:0] a, input logic exp);
      @(posedge MCLK);
      send <= 1'b1;
      p_hop <= h;
      p_net <= n;
      p_addr <= a;
      @(posedge MCLK);
      send <= 1'b0;
      @(posedge MCLK);
      #1 `CHK(RX_ACCEPT, exp)
   endtask : rx
   // header length tolerance is one millisecond of tick phase
   task automatic tx(input int hdr);
      int n;
      n = 1;
      @(posedge MCLK);
      TX_REQ <= 1'b1;
      @(posedge MCLK);
      TX_REQ <= 1'b0;
      #1 `CHK(HDR_ON, hdr != 0)
      while (TX_GO !== 1'b1 && n < hdr * MSC + 20) begin
         @(posedge MCLK);
         #1 n++;
      end
      `CHK(n >= hdr * MSC - MSC && n <= hdr * MSC + 1, 1'b1)
      $display("tx test done, header %0d ms, %0d cycles", hdr, n);
   endtask : tx
   task automatic duty(input int span, input int exp);
      int hi;
      hi = 0;
      repeat (span) begin
         @(posedge MCLK);
         #1 hi += int'(RX_PWR === 1'b1);
      end
      `CHK(hi, exp)
      $display("duty test done, %0d of %0d cycles powered", hi, span);
   endtask : duty
   // hang guard: the whole run needs well under 600 us
   initial begin
      #1_000_000;
      errors++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge MCLK);
      RST <= 1'b0;
      rdc(rldcc_pkg::ADR_CTRL, 16'h0012);
      rdc(8'h1c, 16'h0000);
      rdc(rldcc_pkg::ADR_IDLE, 16'h03e8);
      @(posedge MCLK);
      #1 `CHK(RDATA, 16'h0000)
      $display("reset test done");
      wr(rldcc_pkg::ADR_BAUD, 16'h0005);
      foreach (rows[i]) begin
         wr(rldcc_pkg::ADR_CTRL, rows[i].ctrl);
         repeat (2) @(posedge MCLK);
         #1 `CHK(RAW_FWD, rows[i].raw)
         `CHK(ACK_EN, rows[i].ack)
         `CHK(RETRY_EN, rows[i].retry)
         `CHK(BAUD_EN, rows[i].baud_en)
         `CHK(BAUD_SEL, rows[i].baud_sel)
         rdc(rldcc_pkg::ADR_CTRL, rows[i].ctrl);
      end
      $display("mode table done");
      // refusals leave the old value and set the sticky flag
      wr(rldcc_pkg::ADR_CTRL, 16'h0013);
      rdc(rldcc_pkg::ADR_CTRL, 16'h2010);
      // reject, inactive after reset and always-on receiver are all set
      rdc(rldcc_pkg::ADR_STAT, 16'h000b);
      wr(rldcc_pkg::ADR_STAT, 16'h0001);
      rdc(rldcc_pkg::ADR_STAT, 16'h000a);
      wr(rldcc_pkg::ADR_NET, 16'h0004);
      rdc(rldcc_pkg::ADR_NET, 16'h0000);
      wr(rldcc_pkg::ADR_CTRL, 16'h0001);
      wr(rldcc_pkg::ADR_CTRL, 16'h1001);
      rdc(rldcc_pkg::ADR_CTRL, 16'h0001);
      // unused protocol, power and interface codes
      wr(rldcc_pkg::ADR_CTRL, 16'h0030);
      wr(rldcc_pkg::ADR_CTRL, 16'h0600);
      wr(rldcc_pkg::ADR_CTRL, 16'h0005);
      rdc(rldcc_pkg::ADR_CTRL, 16'h0001);
      wr(rldcc_pkg::ADR_NET, 16'h033f);
      wr(rldcc_pkg::ADR_NET, 16'h0040);
      rdc(rldcc_pkg::ADR_NET, 16'h033f);
      // a routed mode cannot be entered while the network number is above 3
      wr(rldcc_pkg::ADR_CTRL, 16'h0012);
      rdc(rldcc_pkg::ADR_CTRL, 16'h0001);
      wr(rldcc_pkg::ADR_RADDR, 16'h03ff);
      wr(rldcc_pkg::ADR_RADDR, 16'h0400);
      rdc(rldcc_pkg::ADR_RADDR, 16'h03ff);
      `CHK(RF_ID, 12'h3ff)
      rx(4'h3, 6'h3f, 10'h3ff, 1'b1);
      rx(4'h2, 6'h3f, 10'h3ff, 1'b0);
      rx(4'h3, 6'h3e, 10'h3ff, 1'b0);
      rx(4'h3, 6'h3f, 10'h3fe, 1'b0);
      wr(rldcc_pkg::ADR_NET, 16'h0302);
      wr(rldcc_pkg::ADR_CTRL, 16'h0012);
      rx(4'h3, 6'h02, 10'h000, 1'b1);
      `CHK(RF_ID, 12'h5a5)
      @(posedge MCLK);
      SER_ROUTE_ADDR <= 12'h0c3;
      repeat (2) @(posedge MCLK);
      #1 `CHK(RF_ID, 12'h0c3)
      wr(rldcc_pkg::ADR_NODE, 16'h0123);
      wr(rldcc_pkg::ADR_CTRL, 16'h0022);
      repeat (2) @(posedge MCLK);
      #1 `CHK(RF_ID, 12'h123)
      $display("config and link test done");
      // short idle limit so each wait below makes the link inactive
      wr(rldcc_pkg::ADR_IDLE, 16'h0002);
      wr(rldcc_pkg::ADR_CTRL, 16'h0312);
      repeat (40) @(posedge MCLK);
      tx(700);
      tx(0);
      duty(5000, 1000);
      wr(rldcc_pkg::ADR_CTRL, 16'h0012);
      tx(0);
      duty(200, 200);
      wr(rldcc_pkg::ADR_CTRL, 16'h0112);
      repeat (40) @(posedge MCLK);
      tx(1200);
      wr(rldcc_pkg::ADR_CTRL, 16'h0412);
      duty(10000, 1000);
      wr(rldcc_pkg::ADR_CTRL, 16'h0212);
      repeat (40) @(posedge MCLK);
      TX_REQ <= 1'b1;
      @(posedge MCLK);
      TX_REQ <= 1'b0;
      #1 `CHK(HDR_ON, 1'b1)
      `CHK(TX_READY, 1'b0)
      rdc(rldcc_pkg::ADR_STAT, 16'h000f);
      // reset in mid-header must abort it and restore defaults
      RST <= 1'b1;
      repeat (3) @(posedge MCLK);
      RST <= 1'b0;
      #1 `CHK(HDR_ON, 1'b0)
      rdc(rldcc_pkg::ADR_IDLE, 16'h03e8);
      // phase restarts at reset; near 1050 ms eight-second mode is off, one-second would be on
      wr(rldcc_pkg::ADR_CTRL, 16'h0512);
      repeat (10500) @(posedge MCLK);
      duty(1000, 0);
      $display("header and reset test done");
      summarize();
   end
endmodule : rldcc_top_tb_top
